//--- logic/ipi_consts.svh
`ifndef IPI_CONSTS_SVH
`define IPI_CONSTS_SVH

// system clock divided down to the bus cycle rate
`define IPI_BUS_DIV        8'h02
// bus cycles of inactive then active level, synchronous system
`define IPI_SYNC_BUS_CYC   2'h1
// bus cycles of inactive then active level, asynchronous system
`define IPI_ASYNC_BUS_CYC  2'h2
// length of the internal self-test in system clocks
`define IPI_STEST_CYC      16'h0400
// number of memory words covered by the power-up checksum
`define IPI_CHK_WORDS      4'h8
// checksum value that passes
`define IPI_CHK_GOOD       32'h0000_0000
// interrupt lines are active low
`define IPI_IRQ_ACTIVE     1'b0

`endif

//--- logic/ipi_pkg.sv
package ipi_pkg;

	// initialization sequence
	typedef enum logic [2:0] {
		ST_TEST,
		ST_READ,
		ST_WAIT,
		ST_CHECK,
		ST_RUN,
		ST_FAIL
	} ipi_init_state_type;

	// pin function selects from the interrupt control settings
	typedef struct packed {
		logic a_is_msg;
		logic c_is_ext;
		logic d_is_ack;
		logic async_sys;
	} ipi_irq_mode_type;

	// memory read request toward the bus unit
	typedef struct packed {
		logic       req;
		logic [2:0] idx;
	} ipi_mem_rd_type;

	// open-drain pin drive
	typedef struct packed {
		logic o;
		logic oe;
	} ipi_od_pin_type;

	// requests raised by the interrupt lines
	typedef struct packed {
		logic [3:0] irq;
		logic       msg;
		logic       ext;
	} ipi_req_type;

	// state of one line detector
	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       armed;
		logic [1:0] cnt;
		logic       req;
	} ipi_det_state_type;

	// whole state of the top
	typedef struct packed {
		ipi_init_state_type st;
		logic [15:0]        tcnt;
		logic [3:0]         words;
		logic [31:0]        sum;
		ipi_mem_rd_type     rd;
		logic               err;
		logic               ack;
		logic               ack_busy;
		logic [7:0]         div;
		logic               tick;
		ipi_req_type        req;
	} ipi_top_state_type;

endpackage : ipi_pkg

//--- logic/ipi_line_det.sv
`timescale 1ns/10ps
`include "ipi_consts.svh"

// one interrupt line: synchroniser and inactive-then-active detector
module ipi_line_det (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic en,
	input  wire logic tick,
	input  wire logic [1:0] need,
	// line and request
	input  wire logic pin,
	output logic      req
);

	ipi_pkg::ipi_det_state_type s_q;
	ipi_pkg::ipi_det_state_type s_d;
	logic                       act;

	// only the second stage is looked at
	assign act = (s_q.sync2 == `IPI_IRQ_ACTIVE);
	assign req = s_q.req;

	// count inactive samples, then active samples, per bus cycle
	always_comb begin
		s_d = s_q;
		s_d.sync1 = pin;
		s_d.sync2 = s_q.sync1;
		s_d.req = 1'b0;
		if (!en) begin
			s_d.armed = 1'b0;
			s_d.cnt = 2'h0;
		end else if (tick) begin
			if (!s_q.armed) begin
				if (act) begin
					s_d.cnt = 2'h0;
				end else if (s_q.cnt + 2'h1 >= need) begin
					s_d.armed = 1'b1;
					s_d.cnt = 2'h0;
				end else begin
					s_d.cnt = s_q.cnt + 2'h1;
				end
			end else begin
				if (!act) begin
					s_d.cnt = 2'h0; // still armed, restart active count
				end else if (s_q.cnt + 2'h1 >= need) begin
					s_d.req = 1'b1;
					s_d.armed = 1'b0;
					s_d.cnt = 2'h0;
				end else begin
					s_d.cnt = s_q.cnt + 2'h1;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{sync1: 1'b1, sync2: 1'b1, armed: 1'b0,
				cnt: 2'h0, req: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

endmodule : ipi_line_det

//--- logic/ipi_top.sv
// Overview of operation
// - After reset the init error flag is driven active during the self-test.
// - A passing self-test releases the init error flag.
// - After a passing self-test the first eight memory words are read and summed.
// - A nonzero sum drives the flag active again until the next reset.
// - A zero sum lets initialization go on with the flag inactive.
// - A control setting makes line a a message request or an interrupt.
// - A control setting makes line c a direct interrupt or an external request.
// - In acknowledge mode line d is an open-drain acknowledge output.
// - The acknowledge output is latched and stable through data-state cycles.
`timescale 1ns/10ps
`include "ipi_consts.svh"

module ipi_top #(
	parameter logic [15:0] STEST_CYCLES = `IPI_STEST_CYC,
	parameter logic [7:0]  BUS_DIV      = `IPI_BUS_DIV
) (
	// clock and reset
	input  wire logic                  CLK_SYS,
	input  wire logic                  RST,
	// pin function selects
	input  wire ipi_pkg::ipi_irq_mode_type MODE,
	// self-test result from the core
	input  wire logic                  STEST_PASS,
	// memory read port for the checksum
	output ipi_pkg::ipi_mem_rd_type    MEM_RD,
	input  wire logic                  MEM_RD_VALID,
	input  wire logic [31:0]           MEM_RD_DATA,
	// init status
	output ipi_pkg::ipi_od_pin_type    INIT_ERROR_FLAG,
	output logic                       INIT_DONE,
	// interrupt lines
	input  wire logic                  AGENT_MSG_OR_IRQ_A,
	input  wire logic                  IRQ_LINE_B,
	input  wire logic                  IRQ_C_OR_EXT_REQUEST,
	input  wire logic                  IRQ_D_OR_ACK_IN,
	output ipi_pkg::ipi_od_pin_type    IRQ_D_OR_ACK_OUT,
	// acknowledge transaction control
	input  wire logic                  ACK_START,
	input  wire logic                  ACK_LEVEL,
	input  wire logic                  ACK_DATA_STATE,
	input  wire logic                  ACK_END,
	// requests
	output ipi_pkg::ipi_req_type       REQ
);

	ipi_pkg::ipi_top_state_type s_q;
	ipi_pkg::ipi_top_state_type s_d;
	logic [3:0]                 line_pin;
	logic [3:0]                 line_en;
	logic [3:0]                 line_req;
	logic [1:0]                 need;
	logic                       ack_take;
	logic                       ack_release;
	logic                       rd_done;

	// required bus cycles per phase
	always_comb begin
		if (MODE.async_sys) begin
			need = `IPI_ASYNC_BUS_CYC;
		end else begin
			need = `IPI_SYNC_BUS_CYC;
		end
	end

	// pin of each line detector
	assign line_pin[0] = AGENT_MSG_OR_IRQ_A;
	assign line_pin[1] = IRQ_LINE_B;
	assign line_pin[2] = IRQ_C_OR_EXT_REQUEST;
	assign line_pin[3] = IRQ_D_OR_ACK_IN;

	// line d detector is off while the pin serves as acknowledge
	assign line_en[0] = 1'b1;
	assign line_en[1] = 1'b1;
	assign line_en[2] = 1'b1;
	assign line_en[3] = !MODE.d_is_ack;

	// acknowledge start and release, read answer only while asked for
	assign ack_take = MODE.d_is_ack && ACK_START && !s_q.ack_busy;
	assign ack_release = ACK_END && !ACK_DATA_STATE;
	assign rd_done = MEM_RD_VALID && s_q.rd.req;

	// one detector per interrupt line
	for (genvar i = 0; i < 4; i++) begin : g_line
		ipi_line_det u_det (
			.clk  (CLK_SYS),
			.rst  (RST),
			.en   (line_en[i]),
			.tick (s_q.tick),
			.need (need),
			.pin  (line_pin[i]),
			.req  (line_req[i])
		);
	end

	// registered outputs
	assign MEM_RD = s_q.rd;
	assign INIT_DONE = (s_q.st == ipi_pkg::ST_RUN);
	assign REQ = s_q.req;

	// open-drain pins, only ever pulled low
	assign INIT_ERROR_FLAG.o = 1'b0;
	assign INIT_ERROR_FLAG.oe = s_q.err;
	assign IRQ_D_OR_ACK_OUT.o = 1'b0;
	assign IRQ_D_OR_ACK_OUT.oe = MODE.d_is_ack && s_q.ack;

	// next state
	always_comb begin
		s_d = s_q;

		// bus cycle enable divider
		s_d.tick = 1'b0;
		if (s_q.div + 8'h01 >= BUS_DIV) begin
			s_d.div = 8'h00;
			s_d.tick = 1'b1;
		end else begin
			s_d.div = s_q.div + 8'h01;
		end

		// route detector pulses by pin function
		s_d.req.msg = line_req[0] && MODE.a_is_msg;
		s_d.req.irq[0] = line_req[0] && !MODE.a_is_msg;
		s_d.req.irq[1] = line_req[1];
		s_d.req.ext = line_req[2] && MODE.c_is_ext;
		s_d.req.irq[2] = line_req[2] && !MODE.c_is_ext;
		s_d.req.irq[3] = line_req[3];

		// acknowledge latch, held through data states
		if (!MODE.d_is_ack) begin
			s_d.ack = 1'b0;
			s_d.ack_busy = 1'b0;
		end else if (ack_take) begin
			s_d.ack = (ACK_LEVEL == 1'b0);
			s_d.ack_busy = 1'b1;
		end else if (ack_release) begin
			s_d.ack = 1'b0;
			s_d.ack_busy = 1'b0;
		end

		// initialization sequence
		case (s_q.st)
			ipi_pkg::ST_TEST: begin
				s_d.err = 1'b1;
				if (s_q.tcnt + 16'h0001 >= STEST_CYCLES) begin
					if (STEST_PASS) begin
						s_d.err = 1'b0;
						s_d.st = ipi_pkg::ST_READ;
					end else begin
						s_d.st = ipi_pkg::ST_FAIL;
					end
				end else begin
					s_d.tcnt = s_q.tcnt + 16'h0001;
				end
			end

			ipi_pkg::ST_READ: begin
				s_d.rd.req = 1'b1;
				s_d.rd.idx = s_q.words[2:0];
				s_d.st = ipi_pkg::ST_WAIT;
			end

			ipi_pkg::ST_WAIT: begin
				if (rd_done) begin
					s_d.rd.req = 1'b0;
					s_d.sum = s_q.sum + MEM_RD_DATA;
					s_d.words = s_q.words + 4'h1;
					if (s_q.words + 4'h1 >= `IPI_CHK_WORDS) begin
						s_d.st = ipi_pkg::ST_CHECK;
					end else begin
						s_d.st = ipi_pkg::ST_READ;
					end
				end
			end

			ipi_pkg::ST_CHECK: begin
				if (s_q.sum == `IPI_CHK_GOOD) begin
					s_d.st = ipi_pkg::ST_RUN;
				end else begin
					s_d.err = 1'b1;
					s_d.st = ipi_pkg::ST_FAIL;
				end
			end

			ipi_pkg::ST_RUN: begin
				s_d.err = 1'b0;
			end

			ipi_pkg::ST_FAIL: begin
				s_d.err = 1'b1;
			end

			default: begin
				s_d.st = ipi_pkg::ST_FAIL;
			end
		endcase
	end

	// reset image, error flag active straight from reset
	localparam ipi_pkg::ipi_top_state_type rst_image = '{
		st:       ipi_pkg::ST_TEST,
		tcnt:     16'h0000,
		words:    4'h0,
		sum:      32'h0000_0000,
		rd:       '{req: 1'b0, idx: 3'h0},
		err:      1'b1,
		ack:      1'b0,
		ack_busy: 1'b0,
		div:      8'h00,
		tick:     1'b0,
		req:      '{irq: 4'h0, msg: 1'b0, ext: 1'b0}
	};

	// state register
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s_q <= rst_image;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : ipi_top

//--- verification/ipi_properties.sv
`timescale 1ns/10ps
// watches the init status and pin outputs of the top
module ipi_properties (
	// clock and reset
	input wire logic                      CLK_SYS,
	input wire logic                      RST,
	// watched ports
	input wire ipi_pkg::ipi_irq_mode_type MODE,
	input wire logic                      MEM_RD_VALID,
	input wire logic                      ACK_DATA_STATE,
	input wire ipi_pkg::ipi_mem_rd_type   MEM_RD,
	input wire ipi_pkg::ipi_od_pin_type   INIT_ERROR_FLAG,
	input wire logic                      INIT_DONE,
	input wire ipi_pkg::ipi_od_pin_type   IRQ_D_OR_ACK_OUT,
	input wire ipi_pkg::ipi_req_type      REQ
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// init flag sequence
	chk_flag_test: assert property ($fell(RST) |-> INIT_ERROR_FLAG.oe)
		else $error("flag idle in self-test");
	chk_read_flag: assert property (MEM_RD.req |-> !INIT_ERROR_FLAG.oe)
		else $error("flag active while reading");
	chk_done_flag: assert property (INIT_DONE |-> !INIT_ERROR_FLAG.oe)
		else $error("flag active after pass");
	chk_fail_hold: assert property ($rose(INIT_ERROR_FLAG.oe) |=>
		INIT_ERROR_FLAG.oe [*8]) else $error("fail flag dropped");
	chk_read_hold: assert property ($fell(MEM_RD.req) |->
		$past(MEM_RD_VALID)) else $error("read dropped early");
	// pin function selects, acknowledge hold and single request pulses
	chk_msg_sel: assert property ((REQ.msg || REQ.irq[0]) |->
		REQ.msg == MODE.a_is_msg) else $error("line a wrong kind");
	chk_ext_sel: assert property ((REQ.ext || REQ.irq[2]) |->
		REQ.ext == MODE.c_is_ext) else $error("line c wrong kind");
	chk_ack_hold: assert property (IRQ_D_OR_ACK_OUT.oe && ACK_DATA_STATE
		|=> IRQ_D_OR_ACK_OUT.oe) else $error("ack lost in data");
	chk_req_single: assert property (REQ.irq[1] |=> !REQ.irq[1])
		else $error("line b request repeated");
	chk_ack_no_irq: assert property (MODE.d_is_ack |-> !REQ.irq[3])
		else $error("line d request in ack mode");
endmodule : ipi_properties

bind ipi_top ipi_properties chk (.*);

//--- verification/ipi_mem_model.sv
`timescale 1ns/10ps
// memory behind the checksum read port
module ipi_mem_model (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    rst,
	// latency and corrupt word
	input wire logic [3:0]              lat,
	input wire logic                    bad,
	// read port
	input wire ipi_pkg::ipi_mem_rd_type rd,
	output logic                        vld,
	output logic [31:0]                 data
);
	logic [3:0]  cnt;
	logic [31:0] word;
	// word 7 balances the others to zero unless bad
	assign word = (rd.idx == 3'h7) ? 32'h2222_2224 + {31'h0, bad}
		: 32'h1111_1111 * {29'h0, rd.idx + 3'h1};
	// idle bus shows the inverse word
	assign data = vld ? word : ~word;
	// answer after lat clocks, one-cycle valid
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			vld <= 1'b0;
		end else if (rd.req && !vld && cnt == lat) begin
			vld <= 1'b1;
			cnt <= 4'h0;
		end else begin
			vld <= 1'b0;
			cnt <= (rd.req && !vld) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule : ipi_mem_model

//--- verification/ipi_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
// init cases and pin requests against a counting model
module ipi_tb;
	logic                      clk = 1'b0, rst = 1'b1, stp = 1'b1, bad = 1'b0;
	logic                      ack_s = 1'b0, ack_l = 1'b1, ack_ds = 1'b0;
	logic                      ack_e = 1'b0, vld, done, d_pin;
	logic [3:0]                lines = 4'hF, lat = 4'h0;
	logic [31:0]               data;
	integer                    seed = 32'h5B09_3A9F;
	ipi_pkg::ipi_irq_mode_type mode = '0;
	ipi_pkg::ipi_mem_rd_type   rd;
	ipi_pkg::ipi_od_pin_type   flag, ack_out;
	ipi_pkg::ipi_req_type      req;
	int                        fail_count = 0, n_checks = 0, got[6], reads;
	// clock and open-drain line d with pull-up
	always #4 clk = ~clk;
	assign d_pin = ack_out.oe ? 1'b0 : lines[3];
	ipi_top #(.STEST_CYCLES(16'h0008), .BUS_DIV(8'h02)) dut (
		.CLK_SYS(clk), .RST(rst), .MODE(mode), .STEST_PASS(stp),
		.MEM_RD(rd), .MEM_RD_VALID(vld), .MEM_RD_DATA(data),
		.INIT_ERROR_FLAG(flag), .INIT_DONE(done),
		.AGENT_MSG_OR_IRQ_A(lines[0]), .IRQ_LINE_B(lines[1]),
		.IRQ_C_OR_EXT_REQUEST(lines[2]), .IRQ_D_OR_ACK_IN(d_pin),
		.IRQ_D_OR_ACK_OUT(ack_out), .ACK_START(ack_s), .ACK_LEVEL(ack_l),
		.ACK_DATA_STATE(ack_ds), .ACK_END(ack_e), .REQ(req));
	ipi_mem_model mem (.clk(clk), .rst(rst), .lat(lat), .bad(bad), .rd(rd),
		.vld(vld), .data(data));
	// count request pulses and accepted words
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) got[i] += req.irq[i];
		got[4] += req.msg;
		got[5] += req.ext;
		reads += vld;
	end
	task final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	// inactive then active for the bus cycles of the system
	task pulse_line(input int i);
		int n;
		n = mode.async_sys ? 4 : 2;
		repeat (n + 2) @(posedge clk);
		lines[i] <= 1'b0;
		repeat (n + ($random(seed) & 3)) @(posedge clk);
		lines[i] <= 1'b1;
		repeat (n + 4) @(posedge clk);
	endtask : pulse_line
	// ack with start refused while busy, end refused in data state,
	// then a start whose level leaves the line released
	task ack_run();
		ack_s <= 1'b1;
		ack_l <= 1'b0;
		@(posedge clk);
		ack_l <= 1'b1;
		ack_ds <= 1'b1;
		ack_e <= 1'b1;
		@(posedge clk);
		ack_s <= 1'b0;
		ack_e <= 1'b0;
		#1 `CHK("ack_on", 1'b1, ack_out.oe)
		@(posedge clk);
		ack_ds <= 1'b0;
		ack_e <= 1'b1;
		@(posedge clk);
		ack_e <= 1'b0;
		ack_s <= 1'b1;
		@(posedge clk);
		ack_s <= 1'b0;
		ack_e <= 1'b1;
		#1 `CHK("ack_off", 1'b0, ack_out.oe)
		@(posedge clk);
		ack_e <= 1'b0;
		#1 `CHK("ack_idle", 1'b0, ack_out.oe)
	endtask : ack_run
	// one init case with every line pulsed except line d in acknowledge mode
	task run(input int r);
		@(posedge clk);
		mode <= {r[0], r[1], !r[0], r[0] ^ r[1]};
		bad <= (r == 1);
		stp <= (r != 3);
		lat <= r[1] ? 4'h5 : 4'h0;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		got = '{default:0};
		reads = 0;
		repeat (2) @(posedge clk);
		#1 `CHK("flag_test", 1'b1, flag.oe)
		for (int i = 0; i < 4; i++) if (!(i == 3 && mode.d_is_ack)) pulse_line(i);
		if (mode.d_is_ack) ack_run();
		repeat (150) @(posedge clk);
		#1 `CHK("done", r == 0 || r == 2, done)
		`CHK("flag", r == 1 || r == 3, flag.oe)
		`CHK("flag_o", 1'b0, flag.o)
		`CHK("ack_o", 1'b0, ack_out.o)
		`CHK("reads", r == 3 ? 0 : 8, reads)
		`CHK("irq_a", !mode.a_is_msg, got[0])
		`CHK("msg", mode.a_is_msg, got[4])
		`CHK("irq_b", 1, got[1])
		`CHK("irq_c", !mode.c_is_ext, got[2])
		`CHK("ext", mode.c_is_ext, got[5])
		`CHK("irq_d", !mode.d_is_ack, got[3])
		$display("test %0d done", r);
	endtask : run
	// main sequence
	initial begin
		for (int r = 0; r < 4; r++) run(r);
		final_report();
	end
	// watchdog over the expected run length
	initial begin
		repeat (4000) @(posedge clk);
		fail_count++;
		final_report();
	end
endmodule : ipi_tb
